/* File: otmp_pkg.sv */
/*
  Package for the over-temperature monitor and protection block: register map,
  field positions, reset values, timing constants and carrier structs.
  Assumes a 25 MHz APB clock; analog comparators are outside and arrive as pins.
*/
package otmp_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned SCAN_PERIOD_MS = 512;
  localparam int unsigned SCAN_ON_MS = 4;
  localparam int unsigned XOT_FILTER_MS = 1;
  localparam int unsigned SCAN_PERIOD_CYC = (CLK_HZ / 1000) * SCAN_PERIOD_MS;
  localparam int unsigned SCAN_ON_CYC = (CLK_HZ / 1000) * SCAN_ON_MS;
  localparam int unsigned XOT_FILTER_CYC = (CLK_HZ / 1000) * XOT_FILTER_MS;
  localparam int unsigned CNT_W = 24;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_SELECT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_LEVEL = 8'h14;

  // config fields
  localparam int unsigned CFG_SCAN_OFF = 0;
  localparam int unsigned CFG_FORCE = 1;
  localparam int unsigned CFG_INT_SD_DIS = 2;
  localparam int unsigned CFG_EXT_SD_DIS = 3;
  // control fields: bit0 charge, bit1 discharge, bits 15:8 balance
  localparam int unsigned CTL_CHG = 0;
  localparam int unsigned CTL_DSG = 1;
  localparam int unsigned CTL_BAL_LSB = 8;
  localparam int unsigned BAL_W = 8;
  // status fields
  localparam int unsigned ST_COC = 0;
  localparam int unsigned ST_DOC = 1;
  localparam int unsigned ST_SC = 2;
  localparam int unsigned ST_IOT = 3;
  localparam int unsigned ST_XOT = 4;
  localparam int unsigned ST_W = 5;
  localparam int unsigned SEL_W = 4;
  localparam logic [SEL_W-1:0] SEL_EXT_TEMP = 4'h9;
  localparam logic [SEL_W-1:0] SEL_INT_TEMP = 4'h8;

  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [ST_W-1:0] MASK_RESET = 5'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } otmp_apb_req_s;

  typedef struct packed {
    logic charge_overcurrent_flag;
    logic discharge_overcurrent_flag;
    logic sc;
    logic int_hot;
    logic int_cool;
    logic ext_below;
    logic ext_cool;
  } otmp_sense_s;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [6:0] sense1;
    logic [6:0] sense2;
    logic [3:0] cfg;
    logic chg;
    logic dsg;
    logic [BAL_W-1:0] bal;
    logic [SEL_W-1:0] sel;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic int_shut;
    logic ext_shut;
    logic [CNT_W-1:0] scan_cnt;
    logic [CNT_W-1:0] xot_cnt;
    logic supply;
    logic chg_out;
    logic dsg_out;
    logic [BAL_W-1:0] bal_out;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } otmp_state_s;
endpackage : otmp_pkg

/* File: otmp_monitor.sv */
/*
  Over-temperature monitor and protection with an APB register slave.
  Assumes raw comparator levels and overcurrent event levels arrive from
  outside the clock domain; they are synchronised here.
*/
// Function
// - pulse thermistor supply 4 ms every 512 ms without host action.
// - scan-off config bit stops the periodic supply pulses.
// - supply stays on while selection chooses external temperature.
// - force bit keeps supply on continuously, overriding other sources.
// - external over-temperature after comparator low for more than 1 ms.
// - over-temperature turns off switches and balancing, sets its flag.
// - shutdown holds until temperature falls below recovery threshold.
// - switch and balance writes ignored in shutdown; selection still works.
// - shutdown-disable bits suppress automatic shutdown per source.
// - flags still set when automatic shutdown is disabled.
// - analog output selection is driven from the host-written field.
// - overcurrent flags turn supply on; status read clears them.
module otmp_monitor import otmp_pkg::*; #(
  parameter int unsigned SCAN_PERIOD = SCAN_PERIOD_CYC,
  parameter int unsigned SCAN_ON = SCAN_ON_CYC,
  parameter int unsigned XOT_FILTER = XOT_FILTER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire otmp_sense_s sense,
  output logic thermistor_supply_out,
  output logic charge_switch_ctrl,
  output logic discharge_switch_ctrl,
  output logic [BAL_W-1:0] balance_ctrl,
  output logic [SEL_W-1:0] analog_out_select,
  output logic irq
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction : addr_hit

  otmp_state_s cur;
  otmp_state_s next_cur;
  otmp_apb_req_s req;
  otmp_sense_s s;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [ST_W-1:0] events;
  logic scan_pulse;
  logic ext_fail;
  logic shut;
  logic [31:0] rdata;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    s = otmp_sense_s'(cur.sense2);
    // writes land only at the completing edge, so a held request acts once
    access = req.psel && req.penable;
    wr = access && req.pwrite && cur.pready;
    rd = access && !req.pwrite;
    mapped = addr_hit(req.paddr, ADDR_CONFIG) || addr_hit(req.paddr, ADDR_CONTROL) ||
      addr_hit(req.paddr, ADDR_SELECT) || addr_hit(req.paddr, ADDR_STATUS) ||
      addr_hit(req.paddr, ADDR_IRQ_MASK) || addr_hit(req.paddr, ADDR_LEVEL);

    // two-stage synchronisers; only the second stage is read
    next_cur.sense1 = sense;
    next_cur.sense2 = cur.sense1;

    // periodic scan timer
    if (cur.scan_cnt >= CNT_W'(SCAN_PERIOD - 1)) begin
      next_cur.scan_cnt = '0;
    end else begin
      next_cur.scan_cnt = cur.scan_cnt + 1'b1;
    end
    scan_pulse = !cur.cfg[CFG_SCAN_OFF] && (cur.scan_cnt < CNT_W'(SCAN_ON));

    // external comparator filter, armed only while supply is on
    if (cur.supply && s.ext_below) begin
      if (cur.xot_cnt <= CNT_W'(XOT_FILTER)) begin
        next_cur.xot_cnt = cur.xot_cnt + 1'b1;
      end
    end else begin
      next_cur.xot_cnt = '0;
    end
    ext_fail = cur.xot_cnt > CNT_W'(XOT_FILTER);

    // sticky events; set wins over a read clear
    events = '0;
    events[ST_COC] = s.charge_overcurrent_flag;
    events[ST_DOC] = s.discharge_overcurrent_flag;
    events[ST_SC] = s.sc;
    events[ST_IOT] = s.int_hot;
    events[ST_XOT] = ext_fail;
    // clear once, on the first access edge; a second clear would lose new events
    if (rd && !cur.pready && addr_hit(req.paddr, ADDR_STATUS)) begin
      next_cur.status = events;
    end else begin
      next_cur.status = cur.status | events;
    end

    // shutdown latches, released by the recovery comparators
    if (s.int_hot && !cur.cfg[CFG_INT_SD_DIS]) begin
      next_cur.int_shut = 1'b1;
    end else if (s.int_cool) begin
      next_cur.int_shut = 1'b0;
    end
    if (ext_fail && !cur.cfg[CFG_EXT_SD_DIS]) begin
      next_cur.ext_shut = 1'b1;
    end else if (s.ext_cool) begin
      next_cur.ext_shut = 1'b0;
    end
    shut = cur.int_shut || cur.ext_shut;

    // register writes
    if (wr && addr_hit(req.paddr, ADDR_CONFIG)) begin
      next_cur.cfg = pwdata[3:0];
    end
    if (wr && addr_hit(req.paddr, ADDR_CONTROL) && !shut) begin
      next_cur.chg = pwdata[CTL_CHG];
      next_cur.dsg = pwdata[CTL_DSG];
      next_cur.bal = pwdata[CTL_BAL_LSB +: BAL_W];
    end
    if (wr && addr_hit(req.paddr, ADDR_SELECT)) begin
      next_cur.sel = pwdata[SEL_W-1:0];
    end
    if (wr && addr_hit(req.paddr, ADDR_IRQ_MASK)) begin
      next_cur.mask = pwdata[ST_W-1:0];
    end
    // switches drop on shutdown entry; host must rewrite them afterwards
    if (next_cur.int_shut || next_cur.ext_shut) begin
      next_cur.chg = 1'b0;
      next_cur.dsg = 1'b0;
      next_cur.bal = '0;
    end

    // outputs
    next_cur.supply = scan_pulse || (cur.sel == SEL_EXT_TEMP) || cur.cfg[CFG_FORCE] ||
      (|cur.status[ST_SC:ST_COC]);
    next_cur.chg_out = next_cur.chg;
    next_cur.dsg_out = next_cur.dsg;
    next_cur.bal_out = next_cur.bal;
    next_cur.irq = |(next_cur.status & next_cur.mask);

    // read mux
    rdata = '0;
    if (addr_hit(req.paddr, ADDR_CONFIG)) begin
      rdata[3:0] = cur.cfg;
    end else if (addr_hit(req.paddr, ADDR_CONTROL)) begin
      rdata[CTL_CHG] = cur.chg;
      rdata[CTL_DSG] = cur.dsg;
      rdata[CTL_BAL_LSB +: BAL_W] = cur.bal;
    end else if (addr_hit(req.paddr, ADDR_SELECT)) begin
      rdata[SEL_W-1:0] = cur.sel;
    end else if (addr_hit(req.paddr, ADDR_STATUS)) begin
      rdata[ST_W-1:0] = cur.status;
    end else if (addr_hit(req.paddr, ADDR_IRQ_MASK)) begin
      rdata[ST_W-1:0] = cur.mask;
    end else if (addr_hit(req.paddr, ADDR_LEVEL)) begin
      rdata[0] = cur.supply;
      rdata[1] = cur.int_shut;
      rdata[2] = cur.ext_shut;
    end
    // answer registered: pready rises one cycle into the access phase
    next_cur.pready = access && !cur.pready;
    next_cur.pslverr = access && !cur.pready && !mapped;
    next_cur.prdata = (rd && !cur.pready) ? rdata : '0;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign thermistor_supply_out = cur.supply;
  assign charge_switch_ctrl = cur.chg_out;
  assign discharge_switch_ctrl = cur.dsg_out;
  assign balance_ctrl = cur.bal_out;
  assign analog_out_select = cur.sel;
  assign irq = cur.irq;
endmodule : otmp_monitor

/* File: otmp_monitor_props.sv */
/* port checker for otmp_monitor.
   assumes it is bound to the top module and sees its ports only. */
module otmp_monitor_props import otmp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire otmp_sense_s sense,
  input wire logic thermistor_supply_out,
  input wire logic charge_switch_ctrl,
  input wire logic [SEL_W-1:0] analog_out_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("answer not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  AST_UNMAPPED: assert property (psel && pready && paddr > ADDR_LEVEL |-> pslverr)
    else $error("unmapped access not refused");
  AST_SEL_WRITE: assert property (psel && pready && pwrite && paddr == ADDR_SELECT
    |=> analog_out_select == SEL_W'($past(pwdata)))
    else $error("selection write lost");
  AST_EXT_SUPPLY: assert property (analog_out_select == SEL_EXT_TEMP
    && $past(analog_out_select) == SEL_EXT_TEMP |-> thermistor_supply_out)
    else $error("supply off while external selected");
  AST_OC_SUPPLY: assert property (sense.charge_overcurrent_flag [*4] |-> ##[0:3] thermistor_supply_out)
    else $error("overcurrent did not raise supply");
  // switches only come back through a host write, never by themselves
  AST_CHG_RISE: assert property ($rose(charge_switch_ctrl) |->
    $past(psel) && $past(pready) && $past(pwrite) && $past(paddr) == ADDR_CONTROL)
    else $error("charge switch rose without a write");
endmodule : otmp_monitor_props

/* File: otmp_env_model.sv */
/* far-side thermistor divider and comparator.
   assumes the bench says when the pack is hot. */
module otmp_env_model (
  input wire logic pclk,
  input wire logic thermistor_supply_out,
  input wire logic ext_hot,
  output logic ext_below,
  output logic ext_cool
);
  logic tog = 1'b0;
  always @(posedge pclk) tog <= !tog;
  // unpowered divider gives no valid level, so it wobbles
  assign ext_below = thermistor_supply_out ? ext_hot : tog;
  assign ext_cool = !ext_hot;
endmodule : otmp_env_model

/* File: tb.sv */
/* self-checking bench for otmp_monitor with short scan and filter counts.
   assumes the checker and far-side model files are compiled first. */
module tb import otmp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, supply, chg, dsg, irq, ext_below, ext_cool;
  logic [BAL_W-1:0] bal;
  logic [SEL_W-1:0] sel;
  logic [2:0] oc = 3'h0;
  logic int_hot = 1'b0, ext_hot = 1'b0;
  logic [32:0] n, exp_q[$];
  otmp_sense_s sense;
  int error_cnt = 0, checks_done = 0, seed = 73905;
  assign sense = {oc, int_hot, !int_hot, ext_below, ext_cool};
  otmp_monitor #(.SCAN_PERIOD(64), .SCAN_ON(4), .XOT_FILTER(3)) u_otmp_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense(sense), .thermistor_supply_out(supply), .charge_switch_ctrl(chg),
    .discharge_switch_ctrl(dsg), .balance_ctrl(bal), .analog_out_select(sel), .irq(irq));
  otmp_env_model u_otmp_env_model (.pclk(pclk), .thermistor_supply_out(supply),
    .ext_hot(ext_hot), .ext_below(ext_below), .ext_cool(ext_cool));
  initial forever #20 pclk = !pclk;
  task cmp(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task count_on(input logic [32:0] e);
    repeat (3) @(posedge pclk);
    n = 33'h0;
    repeat (64) begin
      @(negedge pclk);
      n = n + 33'(supply);
    end
    cmp(n, e);
  endtask : count_on
  task pulse(input logic [2:0] v);
    @(posedge pclk);
    oc <= v;
    repeat (4) @(posedge pclk);
    oc <= 3'h0;
    repeat (4) @(posedge pclk);
  endtask : pulse
  task outs(input logic [32:0] e);
    repeat (8) @(posedge pclk);
    @(negedge pclk) cmp(33'({chg, dsg, bal}), e);
  endtask : outs
  // read data is judged where it appears, against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) cmp({pslverr, prdata}, exp_q.pop_front());
  end
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CONFIG, 33'h0);
    rd(ADDR_IRQ_MASK, 33'h0);
    rd(8'h40, 33'h100000000);
    count_on(33'd4);
    wr(ADDR_CONFIG, 32'h1);
    count_on(33'd0);
    wr(ADDR_CONFIG, 32'h3);
    count_on(33'd64);
    wr(ADDR_CONFIG, 32'h1);
    wr(ADDR_SELECT, 32'(SEL_EXT_TEMP));
    count_on(33'd64);
    $display("end supply");
    repeat (6) begin
      r = $random(seed);
      wr(ADDR_SELECT, r);
      repeat (250) @(posedge pclk); // settling wait
      @(negedge pclk) cmp(33'(sel), 33'(r[SEL_W-1:0]));
    end
    wr(ADDR_SELECT, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1f);
    for (int i = 0; i < 3; i++) begin
      pulse(3'b100 >> i);
      @(negedge pclk) cmp(33'({supply, irq}), 33'h3);
      rd(ADDR_STATUS, 33'h1 << i);
      repeat (3) @(posedge pclk);
      @(negedge pclk) cmp(33'({supply, irq}), 33'h0);
    end
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_CONTROL, 32'hff03);
    pulse(3'b100);
    @(negedge pclk) cmp(33'(irq), 33'h0);
    rd(ADDR_STATUS, 33'h1);
    // a repeated charge overcurrent: the host keeps the switches off
    wr(ADDR_CONTROL, 32'h0);
    outs(33'h0);
    $display("end overcurrent");
    wr(ADDR_CONTROL, 32'hff03);
    outs(33'h3ff);
    @(posedge pclk) ext_hot <= 1'b1;
    wr(ADDR_CONFIG, 32'h3);
    outs(33'h0);
    wr(ADDR_CONTROL, 32'hff03);
    wr(ADDR_SELECT, 32'(SEL_INT_TEMP));
    outs(33'h0);
    @(negedge pclk) cmp(33'(sel), 33'(SEL_INT_TEMP));
    rd(ADDR_STATUS, 33'h10);
    rd(ADDR_LEVEL, 33'h5);
    ext_hot <= 1'b0;
    repeat (200) @(posedge pclk); // cooling wait
    rd(ADDR_LEVEL, 33'h1);
    rd(ADDR_STATUS, 33'h10);
    wr(ADDR_CONTROL, 32'hff03);
    outs(33'h3ff);
    $display("end external");
    wr(ADDR_CONFIG, 32'h5);
    int_hot <= 1'b1;
    outs(33'h3ff);
    rd(ADDR_STATUS, 33'h8);
    wr(ADDR_CONFIG, 32'h1);
    outs(33'h0);
    @(posedge pclk) int_hot <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(ADDR_STATUS, 33'h8);
    $display("end internal");
    test_done();
  end
endmodule : tb
bind otmp_monitor otmp_monitor_props u_otmp_monitor_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
  .thermistor_supply_out(thermistor_supply_out), .charge_switch_ctrl(charge_switch_ctrl),
  .analog_out_select(analog_out_select));
